// >>> design/rcb_defs.vh
// Constants for the regulator control register bank.
// Assumes inclusion by its bare name from the design file that uses it.
`ifndef RCB_DEFS_VH
`define RCB_DEFS_VH

// Register indices; byte address on the bus is four times the index.
`define RCB_IDX_TEN_CTRL 10'h081
`define RCB_IDX_ELEVEN_VOLT 10'h090
`define RCB_IDX_ELEVEN_CTRL 10'h091
`define RCB_IDX_TWELVE_VOLT 10'h0a0
`define RCB_IDX_TWELVE_CTRL 10'h0a1
`define RCB_IDX_AON_CTRL 10'h0b1
`define RCB_IDX_BTN_CTRL 10'h0c0
`define RCB_IDX_IRQ_SRC 10'h0c1
`define RCB_IDX_IRQ_STATUS 10'h0d0
`define RCB_IDX_IRQ_MASK 10'h0d1

// Control register fields.
`define RCB_CTRL_ON 7
`define RCB_CTRL_DSCH 2
`define RCB_CTRL_FIE 1
`define RCB_CTRL_PG 0
`define RCB_VOLT_MSB 5

// Push-button control fields.
`define RCB_BTN_PRESS_IE 7
`define RCB_BTN_RELEASE_IE 6

// Interrupt source codes: the low byte of the raising block's control index.
`define RCB_SRC_TEN 8'h81
`define RCB_SRC_ELEVEN 8'h91
`define RCB_SRC_TWELVE 8'ha1
`define RCB_SRC_BTN 8'hc0

// Interrupt status and mask bit positions.
`define RCB_IRQ_FAULT10 0
`define RCB_IRQ_FAULT11 1
`define RCB_IRQ_FAULT12 2
`define RCB_IRQ_PRESS 3
`define RCB_IRQ_RELEASE 4
`define RCB_IRQ_BITS 5

// Reset values.
`define RCB_RST_CTRL 8'h00
`define RCB_RST_VOLT 6'h00
`define RCB_RST_IRQ_SRC 8'hff
`define RCB_RST_MASK 5'h00

// Bus responses.
`define RCB_RESP_OKAY 2'b00
`define RCB_RESP_SLVERR 2'b10

`endif

// >>> design/rcb_regbank.v
// Regulator control and push-button interrupt register bank, AXI4-Lite slave.
// Assumes power-good levels and the push-button pin are asynchronous to clk.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_defs.vh"

module rcb_regbank (
    // Clock and reset
    input wire clk,
    input wire rst,
    // AXI4-Lite write address and data
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog side: index 0 is regulator ten, 1 eleven, 2 twelve
    input wire [2:0] power_good,
    input wire pushbutton_input_n,
    output reg [2:0] regulator_enable,
    output reg always_on_regulator_enable,
    output reg [2:0] discharge_active,
    output reg [5:0] regulator_eleven_code,
    output reg [5:0] regulator_twelve_code,
    // Interrupt
    output reg irq
);

    // Register state.
    reg [2:0] fault_irq_enable;
    reg [2:0] output_discharge_enable;
    reg press_irq_enable;
    reg release_irq_enable;
    reg [7:0] irq_source_addr;
    reg [`RCB_IRQ_BITS-1:0] irq_status;
    reg [`RCB_IRQ_BITS-1:0] irq_mask;

    // Synchronisers and edge history.
    reg [2:0] pg_meta;
    reg [2:0] pg_sync;
    reg [2:0] pg_prev;
    reg btn_meta;
    reg btn_sync;
    reg btn_prev;

    // Bus capture.
    reg aw_got;
    reg w_got;
    reg [9:0] wr_idx;
    reg [7:0] wr_byte;
    reg wr_lane;

    wire [9:0] rd_idx;
    wire wr_fire;
    wire rd_fire;
    reg wr_hit;
    reg rd_hit;
    reg [7:0] rd_byte;
    reg [2:0] fault_evt;
    reg press_evt;
    reg release_evt;
    reg [`RCB_IRQ_BITS-1:0] events;
    reg [`RCB_IRQ_BITS-1:0] w1c;
    reg [`RCB_IRQ_BITS-1:0] next_status;
    reg [7:0] next_src;
    reg src_read;

    assign rd_idx = s_axi_araddr[11:2];
    assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;

    // Only the first flop of each pair is read by the second.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_meta <= 3'h0;
            pg_sync <= 3'h0;
            pg_prev <= 3'h0;
            btn_meta <= 1'b1;
            btn_sync <= 1'b1;
            btn_prev <= 1'b1;
        end else begin
            pg_meta <= power_good;
            pg_sync <= pg_meta;
            pg_prev <= pg_sync;
            btn_meta <= pushbutton_input_n;
            btn_sync <= btn_meta;
            btn_prev <= btn_sync;
        end
    end

    // Event detection on synchronised levels.
    always @* begin
        fault_evt = pg_prev & ~pg_sync & regulator_enable & fault_irq_enable;
        press_evt = btn_prev & ~btn_sync & press_irq_enable;
        release_evt = ~btn_prev & btn_sync & release_irq_enable;
        events = {release_evt, press_evt, fault_evt};
    end

    // Read multiplexer.
    always @* begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (rd_idx)
            `RCB_IDX_TEN_CTRL: rd_byte = {regulator_enable[0], 4'h0,
                output_discharge_enable[0], fault_irq_enable[0], pg_sync[0]};
            `RCB_IDX_ELEVEN_CTRL: rd_byte = {regulator_enable[1], 4'h0,
                output_discharge_enable[1], fault_irq_enable[1], pg_sync[1]};
            `RCB_IDX_TWELVE_CTRL: rd_byte = {regulator_enable[2], 4'h0,
                output_discharge_enable[2], fault_irq_enable[2], pg_sync[2]};
            `RCB_IDX_ELEVEN_VOLT: rd_byte = {2'b00, regulator_eleven_code};
            `RCB_IDX_TWELVE_VOLT: rd_byte = {2'b00, regulator_twelve_code};
            `RCB_IDX_AON_CTRL: rd_byte = {always_on_regulator_enable, 7'h00};
            `RCB_IDX_BTN_CTRL: rd_byte = {press_irq_enable, release_irq_enable, 6'h00};
            `RCB_IDX_IRQ_SRC: rd_byte = irq_source_addr;
            `RCB_IDX_IRQ_STATUS: rd_byte = {3'b000, irq_status};
            `RCB_IDX_IRQ_MASK: rd_byte = {3'b000, irq_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // Write decode hit check.
    always @* begin
        case (wr_idx)
            `RCB_IDX_TEN_CTRL: wr_hit = 1'b1;
            `RCB_IDX_ELEVEN_CTRL: wr_hit = 1'b1;
            `RCB_IDX_TWELVE_CTRL: wr_hit = 1'b1;
            `RCB_IDX_ELEVEN_VOLT: wr_hit = 1'b1;
            `RCB_IDX_TWELVE_VOLT: wr_hit = 1'b1;
            `RCB_IDX_AON_CTRL: wr_hit = 1'b1;
            `RCB_IDX_BTN_CTRL: wr_hit = 1'b1;
            `RCB_IDX_IRQ_SRC: wr_hit = 1'b1;
            `RCB_IDX_IRQ_STATUS: wr_hit = 1'b1;
            `RCB_IDX_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Sticky status: a new event wins over a one written to clear it.
    always @* begin
        w1c = {`RCB_IRQ_BITS{1'b0}};
        if (wr_fire && wr_lane && wr_idx == `RCB_IDX_IRQ_STATUS) begin
            w1c = wr_byte[`RCB_IRQ_BITS-1:0];
        end
        next_status = (irq_status & ~w1c) | events;
    end

    // The source byte follows the newest event; an event in the reading cycle
    // wins so that it is never lost to the automatic return to ff.
    always @* begin
        src_read = rd_fire && rd_idx == `RCB_IDX_IRQ_SRC;
        next_src = irq_source_addr;
        if (src_read) begin
            next_src = `RCB_RST_IRQ_SRC;
        end
        if (press_evt || release_evt) begin
            next_src = `RCB_SRC_BTN;
        end
        if (fault_evt[2]) begin
            next_src = `RCB_SRC_TWELVE;
        end
        if (fault_evt[1]) begin
            next_src = `RCB_SRC_ELEVEN;
        end
        if (fault_evt[0]) begin
            next_src = `RCB_SRC_TEN;
        end
    end

    // Write channel: address and data are taken independently, in any order.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCB_RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_idx <= 10'h000;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_got & s_axi_awvalid & ~s_axi_awready;
            s_axi_wready <= ~w_got & s_axi_wvalid & ~s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                wr_idx <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RCB_RESP_OKAY : `RCB_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one outstanding read, answered the cycle after acceptance.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RCB_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & s_axi_arvalid & ~s_axi_arready;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? `RCB_RESP_OKAY : `RCB_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Register file updates; only byte lane 0 carries data.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regulator_enable <= 3'h0;
            output_discharge_enable <= 3'h0;
            fault_irq_enable <= 3'h0;
            always_on_regulator_enable <= 1'b0;
            regulator_eleven_code <= `RCB_RST_VOLT;
            regulator_twelve_code <= `RCB_RST_VOLT;
            press_irq_enable <= 1'b0;
            release_irq_enable <= 1'b0;
            irq_mask <= `RCB_RST_MASK;
        end else if (wr_fire && wr_lane) begin
            case (wr_idx)
                `RCB_IDX_TEN_CTRL: begin
                    regulator_enable[0] <= wr_byte[`RCB_CTRL_ON];
                    output_discharge_enable[0] <= wr_byte[`RCB_CTRL_DSCH];
                    fault_irq_enable[0] <= wr_byte[`RCB_CTRL_FIE];
                end
                `RCB_IDX_ELEVEN_CTRL: begin
                    regulator_enable[1] <= wr_byte[`RCB_CTRL_ON];
                    output_discharge_enable[1] <= wr_byte[`RCB_CTRL_DSCH];
                    fault_irq_enable[1] <= wr_byte[`RCB_CTRL_FIE];
                end
                `RCB_IDX_TWELVE_CTRL: begin
                    regulator_enable[2] <= wr_byte[`RCB_CTRL_ON];
                    output_discharge_enable[2] <= wr_byte[`RCB_CTRL_DSCH];
                    fault_irq_enable[2] <= wr_byte[`RCB_CTRL_FIE];
                end
                `RCB_IDX_ELEVEN_VOLT: begin
                    regulator_eleven_code <= wr_byte[`RCB_VOLT_MSB:0];
                end
                `RCB_IDX_TWELVE_VOLT: begin
                    regulator_twelve_code <= wr_byte[`RCB_VOLT_MSB:0];
                end
                `RCB_IDX_AON_CTRL: begin
                    always_on_regulator_enable <= wr_byte[`RCB_CTRL_ON];
                end
                `RCB_IDX_BTN_CTRL: begin
                    press_irq_enable <= wr_byte[`RCB_BTN_PRESS_IE];
                    release_irq_enable <= wr_byte[`RCB_BTN_RELEASE_IE];
                end
                `RCB_IDX_IRQ_MASK: begin
                    irq_mask <= wr_byte[`RCB_IRQ_BITS-1:0];
                end
                default: begin
                    irq_mask <= irq_mask;
                end
            endcase
        end
    end

    // Interrupt state and derived analog controls. The discharge path follows the
    // enable one cycle late, so it stays closed for one cycle after the regulator turns on.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= {`RCB_IRQ_BITS{1'b0}};
            irq_source_addr <= `RCB_RST_IRQ_SRC;
            irq <= 1'b0;
            discharge_active <= 3'h0;
        end else begin
            irq_status <= next_status;
            irq_source_addr <= next_src;
            irq <= |(next_status & irq_mask);
            discharge_active <= output_discharge_enable & ~regulator_enable;
        end
    end

endmodule // rcb_regbank
`default_nettype wire

// >>> dv/rcb_chk.sv
// Checker on the register bank bus and regulator outputs.
// Assumes a bind onto rcb_regbank; byte address is four times the index.
`timescale 1ns/1ps
`default_nettype none
module rcb_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Regulator side
    input wire logic [2:0] regulator_enable,
    input wire logic [2:0] discharge_active,
    input wire logic [5:0] regulator_eleven_code
);
    logic [9:0] wa, ra;
    logic [7:0] wd;
    // Last taken address and data, so that a response can be tied to its request.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wa <= 10'h000;
            ra <= 10'h000;
            wd <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr[11:2];
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr[11:2];
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
    // The response flop is loaded one edge after both items are held, so it is seen two later.
    a_write_answer: assert property (s_aw and s_w |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_resp_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read ready held");
    a_enable_write: assert property (
        $rose(s_axi_bvalid) && wa == 10'h081 |-> ##[0:1] regulator_enable[0] == wd[7])
        else $error("enable does not follow write");
    a_code_write: assert property (
        $rose(s_axi_bvalid) && wa == 10'h090 |-> ##[0:1] regulator_eleven_code == wd[5:0])
        else $error("code does not follow write");
    a_volt_reserved: assert property (s_axi_rvalid && ra == 10'h090 |-> s_axi_rdata[7:6] == 2'b00)
        else $error("reserved voltage bits set");
    a_unmapped_read: assert property (s_axi_rvalid && ra == 10'h3ff |-> s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
    a_unmapped_write: assert property ($rose(s_axi_bvalid) && wa == 10'h3ff |-> s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
    a_discharge_off: assert property (
        (regulator_enable & $past(regulator_enable) & discharge_active) == 3'b000)
        else $error("discharge while regulator on");
endmodule // rcb_chk
bind rcb_regbank rcb_chk u_chk (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_araddr(s_axi_araddr), .s_axi_wdata(s_axi_wdata), .s_axi_rdata(s_axi_rdata),
    .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .regulator_enable(regulator_enable), .discharge_active(discharge_active),
    .regulator_eleven_code(regulator_eleven_code));
`default_nettype wire

// >>> dv/rcb_host.sv
// Host bus master model for the register bank, with write and read tasks.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rcb_host (
    // Clock
    input wire logic clk,
    // Requests to the slave
    output var logic [11:0] awaddr,
    output var logic [11:0] araddr,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic awvalid,
    output var logic wvalid,
    output var logic bready,
    output var logic arvalid,
    output var logic rready,
    // Answers from the slave
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [1:0] bresp,
    input wire logic [1:0] rresp,
    input wire logic [31:0] rdata
);
    // Ready lines stay high, so every response is taken on its first cycle.
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
        {wstrb, bready, rready} = 6'h07;
    end
    task automatic wr(input logic [9:0] i, input logic [7:0] d, output logic [1:0] r);
        logic a, w, ta, tw;
        {a, w} = 2'b00;
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, d};
        {awvalid, wvalid} <= 2'b11;
        while (!a || !w) begin
            @(negedge clk);
            ta = awready && !a;
            tw = wready && !w;
            @(posedge clk);
            // Released lines show inverted values, never the stale ones.
            if (ta) begin awvalid <= 1'b0; awaddr <= ~awaddr; a = 1'b1; end
            if (tw) begin wvalid <= 1'b0; wdata <= ~wdata; w = 1'b1; end
        end
        do @(negedge clk); while (!bvalid);
        r = bresp;
        @(posedge clk);
    endtask
    task automatic rd(input logic [9:0] i, output logic [7:0] d, output logic [1:0] r);
        logic t;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        do begin @(negedge clk); t = arready; @(posedge clk); end while (!t);
        arvalid <= 1'b0;
        araddr <= ~araddr;
        do @(negedge clk); while (!rvalid);
        {d, r} = {rdata[7:0], rresp};
        @(posedge clk);
    endtask
endmodule // rcb_host
`default_nettype wire

// >>> dv/tb_regulator_control_register_bank.sv
// Self-checking bench for the regulator register bank.
// Assumes rcb_host as bus master and rcb_chk bound onto the design.
`timescale 1ns/1ps
`default_nettype none
module tb_regulator_control_register_bank;
    logic clk = 0, rst = 1, btn_n = 1;
    logic [2:0] pg = 3'b101;
    wire [11:0] awa, ara;
    wire [31:0] wda, rda;
    wire [3:0] wst;
    wire [1:0] brs, rrs;
    wire awv, awr, wv, wr_, brd, bv, arv, arr, rv, rrd, irq, aon;
    wire [2:0] en, dsch;
    wire [5:0] c11, c12;
    int mismatches, check_count, seed = 25740, k;
    logic [7:0] d, mdl [7];
    logic [1:0] r;
    logic [9:0] idx [7] = '{10'h081, 10'h090, 10'h091, 10'h0a0, 10'h0a1, 10'h0b1, 10'h0c0};
    logic [7:0] wm [7] = '{8'h86, 8'h3f, 8'h86, 8'h3f, 8'h86, 8'h80, 8'hc0};
    rcb_regbank DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wda), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rda),
        .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rrd), .power_good(pg),
        .pushbutton_input_n(btn_n), .regulator_enable(en), .always_on_regulator_enable(aon),
        .discharge_active(dsch), .regulator_eleven_code(c11), .regulator_twelve_code(c12),
        .irq(irq));
    rcb_host host (.clk(clk), .awaddr(awa), .araddr(ara), .wdata(wda), .wstrb(wst),
        .awvalid(awv), .wvalid(wv), .bready(brd), .arvalid(arv), .rready(rrd), .awready(awr),
        .wready(wr_), .bvalid(bv), .arready(arr), .rvalid(rv), .bresp(brs), .rresp(rrs),
        .rdata(rda));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task rdc(input logic [9:0] i, input logic [7:0] e);
        host.rd(i, d, r);
        chk(d, e);
        chk({6'h0, r}, 8'h00);
    endtask
    task wrc(input logic [9:0] i, input logic [7:0] v);
        host.wr(i, v, r);
        chk({6'h0, r}, 8'h00);
    endtask
    // Model of a register's read value; control bit 0 is the live power-good level.
    function automatic logic [7:0] ex(int n);
        return mdl[n] | ((n % 2 == 0 && n < 6) ? {7'h0, pg[n / 2]} : 8'h00);
    endfunction
    task irqc(input logic e);
        @(negedge clk);
        chk({7'h0, irq}, {7'h0, e});
        @(posedge clk);
    endtask
    task pin(input logic [2:0] p, input logic b);
        pg <= p;
        btn_n <= b;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        for (k = 0; k < 7; k++) mdl[k] = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 7; k++) rdc(idx[k], ex(k));
        rdc(10'h0c1, 8'hff);
        host.rd(10'h3ff, d, r);
        chk({r, d[5:0]}, 8'h80);
        host.wr(10'h3ff, 8'hff, r);
        chk({6'h0, r}, 8'h02);
        repeat (24) begin
            k = ($random(seed) & 32'h7fff) % 7;
            d = 8'($random(seed));
            wrc(idx[k], d);
            mdl[k] = d & wm[k];
            rdc(idx[k], ex(k));
            chk({5'h0, en}, {5'h0, mdl[4][7], mdl[2][7], mdl[0][7]});
            chk({7'h0, aon}, {7'h0, mdl[5][7]});
            chk({5'h0, dsch}, {5'h0, mdl[4][2] & ~mdl[4][7], mdl[2][2] & ~mdl[2][7],
                mdl[0][2] & ~mdl[0][7]});
            chk({2'b00, c11}, {2'b00, mdl[1][5:0]});
            chk({2'b00, c12}, {2'b00, mdl[3][5:0]});
        end
        wrc(10'h081, 8'h82);
        wrc(10'h0a1, 8'h80);
        wrc(10'h0d1, 8'h1f);
        pin(3'b000, 1'b1);
        irqc(1'b1);
        rdc(10'h0d0, 8'h01);
        rdc(10'h0c1, 8'h81);
        rdc(10'h0c1, 8'hff);
        wrc(10'h0d0, 8'h01);
        irqc(1'b0);
        wrc(10'h0c0, 8'hc0);
        pin(3'b000, 1'b0);
        irqc(1'b1);
        rdc(10'h0c1, 8'hc0);
        wrc(10'h0d0, 8'h08);
        wrc(10'h0d1, 8'h00);
        pin(3'b000, 1'b1);
        irqc(1'b0);
        rdc(10'h0d0, 8'h10);
        wrc(10'h0d0, 8'h10);
        wrc(10'h0c0, 8'h40);
        pin(3'b000, 1'b0);
        rdc(10'h0d0, 8'h00);
        // A second reset in mid-run must bring the source byte back to ff and clear controls.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        irqc(1'b0);
        rdc(10'h0c1, 8'hff);
        rdc(10'h091, 8'h00);
        close_out();
    end
endmodule // tb_regulator_control_register_bank
`default_nettype wire
